/* rtl/acr_defines.vh */
// Purpose: Constants for the converter control and register logic.
// Assumes: AXI4-Lite with 32-bit data; registers in the low byte of each word.
// Notes: Definitions only.
`ifndef ACR_DEFINES_VH
`define ACR_DEFINES_VH
`define ACR_ADDR_W 12
// Each register sits in its own word, so its byte address is four times its index.
`define ACR_OFF_CSR 12'h1C0
`define ACR_OFF_RHI 12'h1C4
`define ACR_OFF_RLO 12'h1C8
`define ACR_IDX_CSR 8'h70
`define ACR_IDX_RHI 8'h71
`define ACR_IDX_RLO 8'h72
`define ACR_OFF_IRQ_STAT 12'h0F0
`define ACR_OFF_IRQ_MASK 12'h0F4
`define ACR_CSR_DONE 7
`define ACR_CSR_SPEED 6
`define ACR_CSR_ON 5
`define ACR_CSR_RSVD 4
`define ACR_CSR_RESET 8'h00
`define ACR_CSR_WMASK 8'h6F
`define ACR_DIV_SLOW 2'h3
`define ACR_DIV_FAST 2'h1
`define ACR_SAMPLE_TICKS 4'h2
`define ACR_RESP_OKAY 2'h0
`define ACR_RESP_SLVERR 2'h2
`endif

/* rtl/acr_sar_core.v */
// Purpose: Successive-approximation sequencer driven by a converter clock tick.
// Assumes: The comparator answer is valid one tick after the trial code is shown.
// Notes: Restart aborts any conversion and begins sampling again.
`timescale 1ns/1ns
`include "acr_defines.vh"
module acr_sar_core #(
   parameter RES_W = 10
) (
   input wire aclk,
   input wire aresetn,
   input wire enable,
   input wire restart,
   input wire tick,
   input wire comp_above,
   output reg sample_hold,
   output reg [RES_W-1:0] trial_code,
   output reg done_pulse,
   output reg [RES_W-1:0] result
);
   localparam ST_IDLE = 2'h0;
   localparam ST_SAMPLE = 2'h1;
   localparam ST_CONV = 2'h2;
   reg [1:0] state_r;
   reg [3:0] cnt_r;
   reg [RES_W-1:0] bit_r;
   always @(posedge aclk) begin
      if (!aresetn) begin
         state_r <= ST_IDLE;
         cnt_r <= 4'h0;
         bit_r <= {RES_W{1'b0}};
         sample_hold <= 1'b0;
         trial_code <= {RES_W{1'b0}};
         done_pulse <= 1'b0;
         result <= {RES_W{1'b0}};
      end else begin
         done_pulse <= 1'b0;
         if (!enable) begin
            state_r <= ST_IDLE;
            sample_hold <= 1'b0;
         end else if (restart || state_r == ST_IDLE) begin
            state_r <= ST_SAMPLE;
            cnt_r <= 4'h0;
            sample_hold <= 1'b1;
         end else if (tick) begin
            case (state_r)
               ST_SAMPLE: begin
                  if (cnt_r == `ACR_SAMPLE_TICKS - 4'h1) begin
                     state_r <= ST_CONV;
                     sample_hold <= 1'b0;
                     bit_r <= {1'b1, {(RES_W-1){1'b0}}};
                     trial_code <= {1'b1, {(RES_W-1){1'b0}}};
                  end else begin
                     cnt_r <= cnt_r + 4'h1;
                  end
               end
               ST_CONV: begin
                  // Each tick settles one bit, most significant first.
                  if (bit_r[0]) begin
                     result <= comp_above ? trial_code : (trial_code & ~bit_r);
                     done_pulse <= 1'b1;
                     state_r <= ST_SAMPLE;
                     cnt_r <= 4'h0;
                     sample_hold <= 1'b1;
                  end else begin
                     trial_code <= (comp_above ? trial_code : (trial_code & ~bit_r)) | (bit_r >> 1);
                  end
                  bit_r <= bit_r >> 1;
               end
               default: state_r <= ST_IDLE;
            endcase
         end
      end
   end
endmodule // acr_sar_core

/* rtl/acr_top.v */
// Purpose: Control and register logic of a 10-bit successive-approximation converter.
// Assumes: AXI4-Lite slave on aclk; analog comparator and multiplexer outside.
// Notes: Result bytes are not latched against each other.
// Notes on behaviour
// - Done flag sets at completion; clears on high-byte read or control write.
// - Done flag read-only; reserved bit four reads zero; other control bits read/write; register resets zero.
// - Converter clock is bus clock over four, or over two when speed set.
// - Clearing converter_on stops conversion; setting it starts converting.
// - Channel mux index equals the four-bit channel_select value.
// - High result byte holds result bits nine to two, resets zero.
// - Low result byte holds bits one and zero; upper six read zero.
// - Control, high and low result bytes decode at three consecutive addresses; the design decodes them a word apart, at 0x1C0, 0x1C4 and 0x1C8.
// - Converts continuously, restarting after each completion while enabled.
// - Channel change aborts conversion, clears done flag, restarts on new channel.
// - Each completion overwrites both result bytes together.
//
// The AXI4-Lite interface to the registers was left to the implementer.
`timescale 1ns/1ns
`include "acr_defines.vh"
module acr_top #(
   parameter RES_W = 10
) (
   input wire aclk,
   input wire aresetn,
   input wire [`ACR_ADDR_W-1:0] s_axi_awaddr,
   input wire [2:0] s_axi_awprot,
   input wire s_axi_awvalid,
   output reg s_axi_awready,
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output reg s_axi_wready,
   output reg [1:0] s_axi_bresp,
   output reg s_axi_bvalid,
   input wire s_axi_bready,
   input wire [`ACR_ADDR_W-1:0] s_axi_araddr,
   input wire [2:0] s_axi_arprot,
   input wire s_axi_arvalid,
   output reg s_axi_arready,
   output reg [31:0] s_axi_rdata,
   output reg [1:0] s_axi_rresp,
   output reg s_axi_rvalid,
   input wire s_axi_rready,
   input wire comp_above,
   output reg [3:0] channel_select,
   output reg converter_on,
   output reg sample_hold,
   output reg [RES_W-1:0] trial_code,
   output reg irq
);
   reg [7:0] csr_r;
   reg [7:0] rhi_r;
   reg [7:0] rlo_r;
   reg irq_stat_r;
   reg irq_mask_r;
   reg [1:0] div_r;
   reg tick_r;
   reg [`ACR_ADDR_W-1:0] aw_addr_r;
   reg [31:0] w_data_r;
   reg [3:0] w_strb_r;
   reg aw_have_r;
   reg w_have_r;
   reg restart_r;
   wire do_write;
   wire do_read;
   wire wr_csr;
   wire wr_hit;
   wire rd_hit;
   wire [7:0] new_csr;
   wire core_sh;
   wire [RES_W-1:0] core_trial;
   wire core_done;
   wire [RES_W-1:0] core_result;
   reg [31:0] rd_val;

   assign do_write = aw_have_r && w_have_r && !s_axi_bvalid;
   assign do_read = s_axi_arvalid && s_axi_arready;
   assign wr_csr = do_write && aw_addr_r == `ACR_OFF_CSR && w_strb_r[0];
   assign wr_hit = aw_addr_r == `ACR_OFF_CSR || aw_addr_r == `ACR_OFF_RHI || aw_addr_r == `ACR_OFF_RLO ||
      aw_addr_r == `ACR_OFF_IRQ_STAT || aw_addr_r == `ACR_OFF_IRQ_MASK;
   assign rd_hit = s_axi_araddr == `ACR_OFF_CSR || s_axi_araddr == `ACR_OFF_RHI ||
      s_axi_araddr == `ACR_OFF_RLO || s_axi_araddr == `ACR_OFF_IRQ_STAT || s_axi_araddr == `ACR_OFF_IRQ_MASK;
   // Reserved bit is dropped, so it always reads zero.
   assign new_csr = w_data_r[7:0] & `ACR_CSR_WMASK;

   always @* begin
      rd_val = 32'h00000000;
      case (s_axi_araddr)
         `ACR_OFF_CSR: rd_val = {24'h000000, csr_r};
         `ACR_OFF_RHI: rd_val = {24'h000000, rhi_r};
         // Upper bits of low byte read zero.
         `ACR_OFF_RLO: rd_val = {24'h000000, 6'h00, rlo_r[1:0]};
         `ACR_OFF_IRQ_STAT: rd_val = {31'h00000000, irq_stat_r};
         `ACR_OFF_IRQ_MASK: rd_val = {31'h00000000, irq_mask_r};
         default: rd_val = 32'h00000000;
      endcase
   end

   always @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `ACR_RESP_OKAY;
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rresp <= `ACR_RESP_OKAY;
         s_axi_rdata <= 32'h00000000;
         aw_have_r <= 1'b0;
         w_have_r <= 1'b0;
         aw_addr_r <= {`ACR_ADDR_W{1'b0}};
         w_data_r <= 32'h00000000;
         w_strb_r <= 4'h0;
      end else begin
         s_axi_awready <= !aw_have_r && !s_axi_awready && s_axi_awvalid;
         s_axi_wready <= !w_have_r && !s_axi_wready && s_axi_wvalid;
         if (s_axi_awvalid && s_axi_awready) begin
            aw_have_r <= 1'b1;
            aw_addr_r <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_have_r <= 1'b1;
            w_data_r <= s_axi_wdata;
            w_strb_r <= s_axi_wstrb;
         end
         if (do_write) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_hit ? `ACR_RESP_OKAY : `ACR_RESP_SLVERR;
            aw_have_r <= 1'b0;
            w_have_r <= 1'b0;
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
         s_axi_arready <= !s_axi_rvalid && !s_axi_arready && s_axi_arvalid;
         if (do_read) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_val;
            s_axi_rresp <= rd_hit ? `ACR_RESP_OKAY : `ACR_RESP_SLVERR;
         end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

   // Control register, result bytes and interrupt status.
   always @(posedge aclk) begin
      if (!aresetn) begin
         csr_r <= `ACR_CSR_RESET;
         rhi_r <= 8'h00;
         rlo_r <= 8'h00;
         irq_stat_r <= 1'b0;
         irq_mask_r <= 1'b0;
         restart_r <= 1'b0;
         irq <= 1'b0;
      end else begin
         restart_r <= 1'b0;
         if (wr_csr) begin
            // Software bits only; done flag is not writable.
            csr_r[6:0] <= new_csr[6:0];
            restart_r <= new_csr[3:0] != csr_r[3:0];
         end
         // Clear on control write or high read; a same-cycle completion wins.
         if (core_done && converter_on && !restart_r) begin
            csr_r[`ACR_CSR_DONE] <= 1'b1;
         end else if (wr_csr || (do_read && s_axi_araddr == `ACR_OFF_RHI)) begin
            csr_r[`ACR_CSR_DONE] <= 1'b0;
         end
         if (core_done && converter_on && !restart_r) begin
            rhi_r <= core_result[RES_W-1:RES_W-8];
            rlo_r <= {6'h00, core_result[1:0]};
         end
         if (core_done && converter_on && !restart_r) begin
            irq_stat_r <= 1'b1;
         end else if (do_write && aw_addr_r == `ACR_OFF_IRQ_STAT && w_strb_r[0] && w_data_r[0]) begin
            irq_stat_r <= 1'b0;
         end
         if (do_write && aw_addr_r == `ACR_OFF_IRQ_MASK && w_strb_r[0]) begin
            irq_mask_r <= w_data_r[0];
         end
         irq <= irq_stat_r && irq_mask_r;
      end
   end

   always @(posedge aclk) begin
      if (!aresetn) begin
         div_r <= 2'h0;
         tick_r <= 1'b0;
      end else begin
         tick_r <= div_r == 2'h0;
         if (div_r == 2'h0) begin
            div_r <= csr_r[`ACR_CSR_SPEED] ? `ACR_DIV_FAST : `ACR_DIV_SLOW;
         end else begin
            div_r <= div_r - 2'h1;
         end
      end
   end

   always @(posedge aclk) begin
      if (!aresetn) begin
         channel_select <= 4'h0;
         converter_on <= 1'b0;
         sample_hold <= 1'b0;
         trial_code <= {RES_W{1'b0}};
      end else begin
         channel_select <= csr_r[3:0];
         converter_on <= csr_r[`ACR_CSR_ON];
         sample_hold <= core_sh;
         trial_code <= core_trial;
      end
   end

   acr_sar_core #(
      .RES_W(RES_W)
   ) u_core (
      .aclk(aclk),
      .aresetn(aresetn),
      .enable(converter_on),
      .restart(restart_r),
      .tick(tick_r),
      .comp_above(comp_above),
      .sample_hold(core_sh),
      .trial_code(core_trial),
      .done_pulse(core_done),
      .result(core_result)
   );
endmodule // acr_top

/* testbench/acr_comp_model.sv */
// Purpose: Comparator and input multiplexer model beside acr_top.
// Assumes: One analog level per channel, set by the bench.
// Notes: Answers at once; the design samples it on converter ticks.
`timescale 1ns/1ns
module acr_comp_model (
   input wire [3:0] channel_select,
   input wire [9:0] trial_code,
   output logic comp_above
);
   logic [9:0] lvl [16];
   assign comp_above = lvl[channel_select] >= trial_code;
endmodule // acr_comp_model

/* testbench/acr_monitor.sv */
// Purpose: Port assertions for acr_top.
// Assumes: One clock, synchronous active-low reset.
// Notes: Bound to every acr_top instance.
`timescale 1ns/1ns
module acr_monitor (
   input wire aclk,
   input wire aresetn,
   input wire s_axi_awready,
   input wire s_axi_bvalid,
   input wire s_axi_bready,
   input wire s_axi_arvalid,
   input wire s_axi_arready,
   input wire s_axi_rvalid,
   input wire s_axi_rready,
   input wire [31:0] s_axi_rdata,
   input wire [3:0] channel_select,
   input wire converter_on,
   input wire sample_hold,
   input wire irq
);
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   sequence s_ar_taken;
      s_axi_arvalid && s_axi_arready;
   endsequence
   // The enable, the sequencer and the output register each add one cycle before sampling stops.
   sequence s_off_three;
      !converter_on [*3];
   endsequence
   AST_RVALID_AFTER_AR: assert property (s_ar_taken |=> s_axi_rvalid)
      else $error("read answer missing");
   AST_RESET_ZERO: assert property (disable iff (1'b0) !aresetn |=> channel_select == 4'h0 && !converter_on && !irq)
      else $error("outputs not zero after reset");
   AST_OFF_NO_SAMPLE: assert property (s_off_three |-> !sample_hold)
      else $error("sampling while off");
   AST_AR_PULSE: assert property (s_axi_arready |=> !s_axi_arready)
      else $error("arready too long");
   AST_AW_PULSE: assert property (s_axi_awready |=> !s_axi_awready)
      else $error("awready too long");
   AST_B_STANDS: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
      else $error("bvalid dropped");
   AST_R_STANDS: assert property (s_axi_rvalid && !s_axi_rready |=> $stable(s_axi_rdata) && s_axi_rvalid)
      else $error("rvalid dropped");
   AST_RDATA_BYTE0: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
      else $error("upper read bits set");
endmodule // acr_monitor
bind acr_top acr_monitor i_mon (.aclk(aclk), .aresetn(aresetn), .s_axi_awready(s_axi_awready),
   .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
   .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
   .s_axi_rdata(s_axi_rdata), .channel_select(channel_select), .converter_on(converter_on),
   .sample_hold(sample_hold), .irq(irq));

/* testbench/acr_top_tb.sv */
// Purpose: Self-checking bench for acr_top.
// Assumes: Register addresses as the design decodes them.
// Notes: Result bytes are read low then high, well before the next completion.
`timescale 1ns/1ns
`include "acr_defines.vh"
module acr_top_tb;
   logic aclk = 0, aresetn = 0, awv = 0, wv = 0, bready = 0, arv = 0, rready = 0;
   logic [`ACR_ADDR_W-1:0] awaddr = {`ACR_ADDR_W{1'b0}}, araddr = {`ACR_ADDR_W{1'b0}};
   logic [31:0] wdata = 32'h0, rdata, d;
   logic [1:0] bresp, rresp;
   logic awready, wready, bvalid, arready, rvalid, comp, on, sh, irq;
   logic [3:0] chan;
   logic [9:0] trial;
   int err_count = 0, samples_checked = 0, cyc = 0, n = 0;
   acr_top i_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
      .s_axi_awvalid(awv), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
      .s_axi_wvalid(wv), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
      .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arv),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .comp_above(comp), .channel_select(chan), .converter_on(on),
      .sample_hold(sh), .trial_code(trial), .irq(irq));
   acr_comp_model i_cmp (.channel_select(chan), .trial_code(trial), .comp_above(comp));
   initial forever #50 aclk = ~aclk;
   // A hang ends the run here instead of stalling the wait loops.
   always @(posedge aclk) begin
      cyc++;
      if (cyc == 30000) begin
         err_count++;
         tally_and_finish();
      end
   end
   task chk(input logic [31:0] g, input logic [31:0] e);
      samples_checked++;
      if (g !== e) begin
         err_count++;
         $display("CHECK FAILED %0t got %h want %h", $time, g, e);
      end
   endtask
   task wr(input logic [`ACR_ADDR_W-1:0] a, input logic [31:0] v);
      logic aw_pend, w_pend;
      aw_pend = 1'b1;
      w_pend = 1'b1;
      awaddr <= a;
      wdata <= v;
      awv <= 1'b1;
      wv <= 1'b1;
      bready <= 1'b1;
      // Each channel is released only at the edge that takes it.
      while (aw_pend || w_pend) begin
         @(posedge aclk);
         if (aw_pend && awready) begin
            awv <= 1'b0;
            aw_pend = 1'b0;
         end
         if (w_pend && wready) begin
            wv <= 1'b0;
            w_pend = 1'b0;
         end
      end
      while (!bvalid) @(posedge aclk);
      bready <= 1'b0;
      // A spare edge lets the registered outputs follow the write before anyone looks.
      @(posedge aclk);
   endtask
   task rd(input logic [`ACR_ADDR_W-1:0] a, output logic [31:0] v);
      araddr <= a; arv <= 1; rready <= 1;
      do @(posedge aclk); while (!arready);
      arv <= 0;
      while (!rvalid) @(posedge aclk);
      v = rdata;
      rready <= 0;
      @(posedge aclk);
   endtask
   task wait_done;
      d = 0;
      while (!d[7]) rd(`ACR_OFF_CSR, d);
   endtask
   task t_reset;
      rd(`ACR_OFF_CSR, d);
      chk(d, 32'h00000000);
      rd(`ACR_OFF_RHI, d);
      chk(d, 32'h00000000);
      rd(`ACR_OFF_RLO, d);
      chk(d, 32'h00000000);
      $display("test reset done");
   endtask
   task t_reset_again;
      aresetn <= 1'b0;
      repeat (3) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      t_reset();
   endtask
   task t_convert(input logic [7:0] csr, input logic [9:0] lv);
      i_cmp.lvl[csr[3:0]] <= lv;
      wr(`ACR_OFF_CSR, {24'h000000, csr});
      chk({on, chan}, {1'b1, csr[3:0]});
      wait_done();
      rd(`ACR_OFF_RLO, d);
      chk(d, {30'h00000000, lv[1:0]});
      rd(`ACR_OFF_RHI, d);
      chk(d, {24'h000000, lv[9:2]});
      rd(`ACR_OFF_CSR, d);
      chk(d, {24'h000000, csr});
      // Sampling right after a completion lasts two converter ticks.
      while (sh) @(posedge aclk);
      while (!sh) @(posedge aclk);
      n = 0;
      while (sh) begin
         @(posedge aclk);
         n++;
      end
      chk(n, `ACR_SAMPLE_TICKS * (csr[6] ? 2 : 4));
      wait_done();
      $display("test convert %h done", csr);
   endtask
   task t_chan_abort;
      i_cmp.lvl[9] <= 10'h1A6;
      wr(`ACR_OFF_CSR, 32'h00000029);
      rd(`ACR_OFF_CSR, d);
      chk(d[7], 1'b0);
      chk(chan, 4'h9);
      $display("test abort done");
   endtask
   task t_irq_bus;
      wr(`ACR_OFF_IRQ_MASK, 32'h00000001);
      wait_done();
      chk(irq, 1'b1);
      wr(`ACR_OFF_CSR, 32'h00000009);
      wr(`ACR_OFF_IRQ_STAT, 32'h00000001);
      chk(irq, 1'b0);
      chk(sh, 1'b0);
      rd(`ACR_OFF_RLO, d);
      chk(d, 32'h00000002);
      rd(`ACR_OFF_RHI, d);
      chk(d, 32'h00000069);
      wr(`ACR_OFF_RHI, 32'h00000055);
      chk(bresp, `ACR_RESP_OKAY);
      rd(`ACR_OFF_RHI, d);
      chk(d, 32'h00000069);
      rd(12'h080, d);
      chk(rresp, `ACR_RESP_SLVERR);
      chk(d, 32'h00000000);
      $display("test irq and bus done");
   endtask
   task tally_and_finish;
      $display("compares %0d mismatches %0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   initial begin
      repeat (10) @(posedge aclk);
      aresetn <= 1;
      @(posedge aclk);
      t_reset();
      t_convert(8'h23, 10'h2B5);
      t_convert(8'h65, 10'h3FF);
      t_convert(8'h20, 10'h000);
      t_convert(8'h2F, 10'h102);
      t_chan_abort();
      t_irq_bus();
      t_reset_again();
      tally_and_finish();
   end
endmodule // acr_top_tb
